// File: logic/disk_status_and_byte_request.sv
// Status byte and per-byte request handshake for read and write commands.
// Assumes a command sequencer that supplies start, done, events and disk bytes.
`timescale 1ns/1ns
`include "disk_status_defines.svh"

module disk_status_and_byte_request
    import disk_status_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic master_clear,
    input wire logic drive_ready,
    input wire logic drive_protect,
    input wire logic drive_fault,
    input wire logic cmd_start,
    input wire op_kind_t cmd_kind,
    input wire logic cmd_done,
    input wire disk_event_t disk_event,
    input wire logic disk_byte_valid,
    input wire logic [7:0] disk_byte,
    output logic disk_byte_ready,
    output logic disk_need_byte,
    output logic [7:0] host_byte_out,
    output logic host_byte_valid,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic byte_request,
    output logic busy,
    output logic completion_irq,
    output logic cmd_refused
);

    // ********************************************
    // State
    // ********************************************
    typedef struct packed {
        op_kind_t op;
        logic busy;
        logic protect;
        logic type_fault;
        logic missing;
        logic crc;
        logic lost;
        logic request;
        logic irq;
        logic refused;
        logic need_byte;
        logic out_valid;
        logic [7:0] out_byte;
        logic [7:0] rdata;
        logic [15:0] timer;
    } blk_state_t;

    localparam logic [15:0] BYTE_CYC = 16'(`BYTE_TIME_CYC);

    blk_state_t s_q;
    blk_state_t s_d;
    logic [7:0] status_now;
    logic buf_valid;
    logic [7:0] buf_data;
    logic buf_pop;
    logic start_ok;
    logic rd_buf;
    logic wr_buf;
    logic rd_stat;
    logic is_write;

    // ********************************************
    // Disk side buffer
    // ********************************************
    // Read bytes wait here until the data latch is free to take them
    byte_pair_buffer u_buf (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .flush(start_ok),
        .in_valid(disk_byte_valid && (s_q.op != op_write) && s_q.busy),
        .in_ready(disk_byte_ready),
        .in_data(disk_byte),
        .out_valid(buf_valid),
        .out_ready(buf_pop),
        .out_data(buf_data)
    );

    // Decode strobes and command acceptance
    assign rd_buf = reg_rd && (reg_addr == `OFS_BUFFER);
    assign wr_buf = reg_wr && (reg_addr == `OFS_BUFFER);
    assign rd_stat = reg_rd && (reg_addr == `OFS_STATUS);
    assign start_ok = cmd_start && drive_ready && !master_clear;
    assign is_write = (s_q.op == op_write);
    // Load a buffered byte into the data latch once the host has emptied it
    assign buf_pop = buf_valid && !s_q.request && s_q.busy && !is_write;

    // Live status byte
    always_comb begin
        status_now = `STATUS_RESET;
        status_now[`BIT_NOT_READY] = !drive_ready || master_clear;
        status_now[`BIT_PROTECT] = s_q.protect;
        status_now[`BIT_TYPE_FAULT] = s_q.type_fault;
        status_now[`BIT_MISSING] = s_q.missing;
        status_now[`BIT_CRC] = s_q.crc;
        status_now[`BIT_LOST] = s_q.lost;
        status_now[`BIT_REQUEST] = s_q.request;
        status_now[`BIT_BUSY] = s_q.busy;
    end

    // ********************************************
    // Next state
    // ********************************************
    always_comb begin
        s_d = s_q;
        s_d.refused = cmd_start && !start_ok;
        s_d.need_byte = 1'b0;
        s_d.out_valid = 1'b0;
        s_d.rdata = 8'h00;
        if (rd_stat) begin
            s_d.rdata = status_now;
            s_d.irq = 1'b0;
        end else if (rd_buf) begin
            s_d.rdata = s_q.out_byte;
        end
        // Host service of the data latch
        if (rd_buf || (wr_buf && is_write)) begin
            s_d.request = 1'b0;
            s_d.timer = 16'h0000;
        end
        if (wr_buf && is_write) begin
            s_d.out_byte = reg_wdata;
            s_d.out_valid = 1'b1;
        end
        // Service timer while a request stands
        if (s_q.request && s_q.busy && !(rd_buf || wr_buf)) begin
            if (s_q.timer == BYTE_CYC - 16'd1) begin
                s_d.lost = 1'b1;
                s_d.timer = 16'h0000;
            end else begin
                s_d.timer = s_q.timer + 16'd1;
            end
        end
        if (s_q.busy) begin
            if (buf_pop) begin
                s_d.out_byte = buf_data;
                s_d.request = 1'b1;
            end
            // Write: the disk asks for the next byte
            if (is_write && disk_byte_valid) begin
                s_d.need_byte = 1'b1;
                if (s_q.request) begin
                    s_d.lost = 1'b1;
                end
                s_d.request = 1'b1;
            end
            if (is_write) begin
                s_d.protect = s_q.protect || drive_protect || disk_event.protect;
                s_d.type_fault = s_q.type_fault || drive_fault
                    || disk_event.write_fault;
            end else if (s_q.op == op_read_record) begin
                s_d.type_fault = s_q.type_fault || disk_event.deleted_mark;
            end
            if (s_q.op != op_read_track) begin
                s_d.missing = s_q.missing || disk_event.missing;
                s_d.crc = s_q.crc || disk_event.crc_error;
            end
            if (cmd_done) begin
                s_d.busy = 1'b0;
                s_d.request = 1'b0;
                s_d.irq = 1'b1;
            end
        end
        // A new command clears the old results
        if (start_ok) begin
            s_d.op = cmd_kind;
            s_d.busy = 1'b1;
            s_d.irq = 1'b0;
            s_d.protect = 1'b0;
            s_d.type_fault = 1'b0;
            s_d.missing = 1'b0;
            s_d.crc = 1'b0;
            s_d.lost = 1'b0;
            s_d.request = 1'b0;
            s_d.timer = 16'h0000;
        end
        // Master clear stops the command but keeps the interrupt
        if (master_clear) begin
            s_d.busy = 1'b0;
            s_d.request = 1'b0;
            s_d.op = op_none;
        end
    end

    // State register
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from flip-flops
    assign reg_rdata = s_q.rdata;
    assign byte_request = s_q.request;
    assign busy = s_q.busy;
    assign completion_irq = s_q.irq;
    assign cmd_refused = s_q.refused;
    assign disk_need_byte = s_q.need_byte;
    assign host_byte_out = s_q.out_byte;
    assign host_byte_valid = s_q.out_valid;

    // ********************************************
    // Checks
    // ********************************************
    sequence host_serves;
        rd_buf || (wr_buf && is_write);
    endsequence

    a_refuse_not_ready: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (cmd_start && !drive_ready && !busy) |=> (!busy && cmd_refused))
        else $error("command accepted with drive not ready");
    a_not_ready_bit: assert property (@(posedge clk_sys) disable iff (!arst_n)
        rd_stat |=> (reg_rdata[`BIT_NOT_READY] == $past(!drive_ready || master_clear)))
        else $error("not ready bit wrong");
    a_request_mirror: assert property (@(posedge clk_sys) disable iff (!arst_n)
        rd_stat |=> (reg_rdata[`BIT_REQUEST] == $past(byte_request)))
        else $error("request bit differs from output");
    a_host_clears: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (host_serves and (!busy || !disk_byte_valid) and !buf_pop) |=> !byte_request)
        else $error("request not cleared by host");
    a_new_op_clear: assert property (@(posedge clk_sys) disable iff (!arst_n)
        start_ok |=> (!byte_request && busy))
        else $error("status not cleared on new command");
    a_busy_done: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (busy && cmd_done && !start_ok) |=> (!busy && completion_irq))
        else $error("busy not cleared at completion");
    a_irq_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (completion_irq && !rd_stat && !start_ok) |=> completion_irq)
        else $error("interrupt dropped without cause");
    a_lost_timeout: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (s_q.request && busy && s_q.timer == BYTE_CYC - 16'd1 && !reg_rd && !reg_wr
         && !start_ok && !master_clear) |=> s_q.lost)
        else $error("lost data not flagged");
    a_read_no_protect: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (busy && !is_write) |-> !s_q.protect)
        else $error("protect bit set during read");

    // Write side steps: the disk asks for a byte, then the host answers
    sequence write_demand;
        busy && is_write && disk_byte_valid && !start_ok && !master_clear && !cmd_done;
    endsequence

    sequence write_answer;
        wr_buf && is_write && !disk_byte_valid && !start_ok;
    endsequence

    // Read side step: a buffered byte moves into the data latch
    sequence read_load;
        buf_pop && !start_ok && !master_clear && !cmd_done;
    endsequence

    a_demand_request: assert property (@(posedge clk_sys) disable iff (!arst_n)
        write_demand |=> (byte_request && disk_need_byte))
        else $error("write demand did not raise the request");
    a_demand_overrun: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (write_demand and byte_request) |=> s_q.lost)
        else $error("overrun of write request not flagged");
    a_write_answer: assert property (@(posedge clk_sys) disable iff (!arst_n)
        write_answer |=> (!byte_request && host_byte_valid && host_byte_out == $past(reg_wdata)))
        else $error("host data write not taken");
    a_load_request: assert property (@(posedge clk_sys) disable iff (!arst_n)
        read_load |=> (byte_request && host_byte_out == $past(buf_data)))
        else $error("buffered byte did not raise the request");

    // Host reads, master clear and sticky error flags
    a_data_read: assert property (@(posedge clk_sys) disable iff (!arst_n)
        rd_buf |=> (reg_rdata == $past(host_byte_out)))
        else $error("data read returned the wrong byte");
    a_master_stop: assert property (@(posedge clk_sys) disable iff (!arst_n)
        master_clear |=> (!busy && !byte_request))
        else $error("master clear left a command running");
    a_missing_set: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (busy && s_q.op != op_read_track && disk_event.missing && !start_ok) |=> s_q.missing)
        else $error("record missing not flagged");
    a_track_clean: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (busy && s_q.op == op_read_track) |-> !(s_q.missing || s_q.crc || s_q.type_fault))
        else $error("error flag set during track read");

endmodule : disk_status_and_byte_request

// File: logic/disk_status_defines.svh
// Constants of the disk status and byte request block.
// Assumes inclusion by bare name from the status block design file.
`ifndef DISK_STATUS_DEFINES_SVH
`define DISK_STATUS_DEFINES_SVH

// ********************************************
// Register offsets on the plain port
// ********************************************
`define OFS_STATUS 2'h0
`define OFS_BUFFER 2'h3

// ********************************************
// Status bit positions
// ********************************************
`define BIT_NOT_READY 7
`define BIT_PROTECT 6
`define BIT_TYPE_FAULT 5
`define BIT_MISSING 4
`define BIT_CRC 3
`define BIT_LOST 2
`define BIT_REQUEST 1
`define BIT_BUSY 0

// ********************************************
// Reset values and timing
// ********************************************
`define STATUS_RESET 8'h00
`define BYTE_TIME_NS 32000
`define CLK_PERIOD_NS 10
`define BYTE_TIME_CYC ((`BYTE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: logic/disk_status_pkg.sv
// Types shared by the disk status block and its byte buffer.
// Assumes the defines header sits beside it.
package disk_status_pkg;

    // Kind of command now running
    typedef enum logic [1:0] {
        op_none,
        op_read_record,
        op_read_track,
        op_write
    } op_kind_t;

    // One byte on its way through the buffer
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } byte_word_t;

    // Condition strobes from the command sequencer
    typedef struct packed {
        logic protect;
        logic deleted_mark;
        logic write_fault;
        logic missing;
        logic crc_error;
    } disk_event_t;

endpackage : disk_status_pkg

// File: logic/byte_pair_buffer.sv
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ns
module byte_pair_buffer
    import disk_status_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [7:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [7:0] out_data
);

    typedef struct packed {
        byte_word_t [1:0] slot;
        logic rd;
        logic wr;
        logic [1:0] count;
    } buf_state_t;

    buf_state_t s_q;
    buf_state_t s_d;
    logic push;
    logic pop;

    // Handshake terms
    assign push = in_valid && (s_q.count != 2'd2);
    assign pop = out_ready && (s_q.count != 2'd0);
    assign in_ready = (s_q.count != 2'd2);
    assign out_valid = (s_q.count != 2'd0);
    assign out_data = s_q.slot[s_q.rd].data;

    // Next state of pointers and slots
    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.slot[s_q.wr].data = in_data;
            s_d.slot[s_q.wr].valid = 1'b1;
            s_d.wr = ~s_q.wr;
        end
        if (pop) begin
            s_d.slot[s_q.rd].valid = 1'b0;
            s_d.rd = ~s_q.rd;
        end
        s_d.count = s_q.count + {1'b0, push} - {1'b0, pop};
        if (flush) begin
            s_d = '0;
        end
    end

    // State register
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule : byte_pair_buffer

// File: sim/host_model.sv
// Host model: bus master for register cycles, auto-serves byte requests.
// Assumes one clock and the plain register port of the status block.
`timescale 1ns/1ns
module host_model (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic byte_request,
    input wire logic go,
    input wire logic go_wr,
    input wire logic [1:0] go_addr,
    input wire logic [7:0] go_wdata,
    input wire logic auto_en,
    input wire logic auto_wr,
    input wire logic [11:0] delay,
    output logic [1:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd
);
    logic [11:0] wait_q;
    logic [7:0] wcnt_q;

    // ***
    // Commanded cycles first, then request service after a delay
    // ***
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            reg_rd <= 1'b0;
            reg_wr <= 1'b0;
            reg_addr <= 2'h0;
            reg_wdata <= 8'h00;
            wait_q <= 12'h000;
            wcnt_q <= 8'h00;
        end else begin
            reg_rd <= 1'b0;
            reg_wr <= 1'b0;
            reg_wdata <= ~reg_wdata; // Idle data never looks valid
            wait_q <= 12'h000;
            if (go) begin
                reg_rd <= !go_wr;
                reg_wr <= go_wr;
                reg_addr <= go_addr;
                reg_wdata <= go_wdata;
            end else if (auto_en && byte_request && !reg_rd && !reg_wr) begin
                wait_q <= wait_q + 12'h001;
                if (wait_q >= delay) begin
                    wait_q <= 12'h000;
                    reg_rd <= !auto_wr;
                    reg_wr <= auto_wr;
                    reg_addr <= 2'h3;
                    reg_wdata <= wcnt_q;
                    wcnt_q <= wcnt_q + {7'h00, auto_wr};
                end
            end
        end
    end
endmodule : host_model

// File: sim/tb_top.sv
// Testbench for the status and byte request block.
// Assumes the package, the buffer and the host model are compiled first.
`timescale 1ns/1ns
module tb_top
    import disk_status_pkg::*;
;
    logic clk_sys, arst_n, master_clear, drive_ready, drive_protect, drive_fault;
    logic cmd_start, cmd_done, disk_byte_valid, go, go_wr, ae, aw;
    logic rd_seen = 1'b0;
    op_kind_t cmd_kind;
    disk_event_t disk_event;
    logic [7:0] disk_byte, gd, host_byte_out, reg_wdata, reg_rdata;
    logic [1:0] ga, reg_addr;
    logic disk_byte_ready, disk_need_byte, host_byte_valid, reg_wr, reg_rd;
    logic byte_request, busy, completion_irq, cmd_refused;
    logic [7:0] rq[$];
    logic [7:0] wq[$];
    logic [31:0] seed;
    int error_cnt, n_tests;

    disk_status_and_byte_request i_dut (.clk_sys, .arst_n, .master_clear, .drive_ready,
        .drive_protect, .drive_fault, .cmd_start, .cmd_kind, .cmd_done, .disk_event,
        .disk_byte_valid, .disk_byte, .disk_byte_ready, .disk_need_byte, .host_byte_out,
        .host_byte_valid, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .byte_request, .busy, .completion_irq, .cmd_refused);
    host_model i_host (.clk_sys, .arst_n, .byte_request, .go, .go_wr, .go_addr(ga),
        .go_wdata(gd), .auto_en(ae), .auto_wr(aw), .delay(12'h003), .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd);

    // ***
    // Clock, checks and helpers
    // ***
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task summarize();
        $display("errors %0d checks %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : summarize

    task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask : chk

    // Read notes the expected value, write sends the data
    task bus(logic w, logic [1:0] a, logic [7:0] d);
        if (!w) rq.push_back(d);
        @(posedge clk_sys) begin go <= 1'b1; go_wr <= w; ga <= a; gd <= d; end
        @(posedge clk_sys) go <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask : bus

    task cmd(op_kind_t k, logic ok);
        @(posedge clk_sys) begin cmd_start <= 1'b1; cmd_kind <= k; end
        @(posedge clk_sys) cmd_start <= 1'b0;
        #1;
        chk("busy", {7'h00, ok}, {7'h00, busy});
        chk("cmd_refused", {7'h00, ~ok}, {7'h00, cmd_refused});
        chk("byte_request", 8'h00, {7'h00, byte_request});
    endtask : cmd

    task fin();
        @(posedge clk_sys) cmd_done <= 1'b1;
        @(posedge clk_sys) cmd_done <= 1'b0;
        #1;
        chk("irq", 8'h01, {7'h00, completion_irq});
    endtask : fin

    task evt(logic [4:0] e);
        @(posedge clk_sys) disk_event <= disk_event_t'(e);
        @(posedge clk_sys) disk_event <= '0;
    endtask : evt

    // Offers one random disk byte and waits for the buffer to take it
    task feed(logic p);
        int i;
        seed = lfsr(seed);
        if (p) rq.push_back(seed[7:0]);
        @(posedge clk_sys) begin disk_byte_valid <= 1'b1; disk_byte <= seed[7:0]; end
        i = 0;
        do @(posedge clk_sys); while (!disk_byte_ready && ++i < 50);
        disk_byte_valid <= 1'b0;
        if (i >= 50) begin error_cnt++; summarize(); end
    endtask : feed

    task drain();
        for (int i = 0; i < 300 && rq.size() != 0; i++) @(posedge clk_sys);
        if (rq.size() != 0) begin error_cnt++; summarize(); end
    endtask : drain

    task demand();
        @(posedge clk_sys) disk_byte_valid <= 1'b1;
        @(posedge clk_sys) disk_byte_valid <= 1'b0;
        #1;
        chk("disk_need_byte", 8'h01, {7'h00, disk_need_byte});
        chk("byte_request", 8'h01, {7'h00, byte_request});
        repeat (10) @(posedge clk_sys);
    endtask : demand

    // Read data and written bytes against the oldest note
    always @(posedge clk_sys) begin
        if (rd_seen) chk("reg_rdata", rq.size() != 0 ? rq.pop_front() : 8'hxx,
            reg_rdata);
        if (host_byte_valid) chk("host_byte_out", wq.size() != 0 ? wq.pop_front() : 8'hxx,
            host_byte_out);
        rd_seen <= reg_rd;
    end

    // ***
    // Main sequence
    // ***
    initial begin
        arst_n = 1'b0; master_clear = 1'b0; drive_ready = 1'b0; drive_protect = 1'b0;
        drive_fault = 1'b0; cmd_start = 1'b0; cmd_done = 1'b0; disk_byte_valid = 1'b0;
        go = 1'b0; go_wr = 1'b0; ae = 1'b0; aw = 1'b0; cmd_kind = op_none;
        disk_event = '0; disk_byte = 8'h00; ga = 2'h0; gd = 8'h00;
        seed = 32'h29b7_20b5; error_cnt = 0; n_tests = 0;
        repeat (6) @(posedge clk_sys);
        arst_n <= 1'b1;
        bus(1'b0, 2'h0, 8'h80);
        master_clear <= 1'b1;
        drive_ready <= 1'b1;
        bus(1'b0, 2'h0, 8'h80);
        master_clear <= 1'b0;
        bus(1'b0, 2'h0, 8'h00);
        bus(1'b0, 2'h1, 8'h00);
        drive_ready <= 1'b0;
        for (int k = 1; k < 4; k++) cmd(op_kind_t'(k), 1'b0);
        drive_ready <= 1'b1;
        cmd(op_read_record, 1'b1);
        evt(5'h1b);
        ae <= 1'b1;
        repeat (4) feed(1'b1);
        drain();
        ae <= 1'b0;
        feed(1'b0);
        repeat (3210) @(posedge clk_sys);
        bus(1'b0, 2'h0, 8'h3f);
        rq.push_back(seed[7:0]);
        ae <= 1'b1;
        drain();
        ae <= 1'b0;
        bus(1'b0, 2'h0, 8'h3d);
        fin();
        bus(1'b0, 2'h0, 8'h3c);
        chk("irq", 8'h00, {7'h00, completion_irq});
        cmd(op_read_track, 1'b1);
        evt(5'h18);
        bus(1'b0, 2'h0, 8'h01);
        fin();
        cmd(op_write, 1'b1);
        bus(1'b0, 2'h0, 8'h01);
        aw <= 1'b1;
        ae <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            wq.push_back(8'(i));
            demand();
        end
        ae <= 1'b0;
        demand();
        demand();
        drive_protect <= 1'b1;
        drive_fault <= 1'b1;
        evt(5'h14);
        bus(1'b0, 2'h0, 8'h67);
        wq.push_back(8'h5a);
        bus(1'b1, 2'h3, 8'h5a);
        bus(1'b0, 2'h0, 8'h65);
        fin();
        chk("wq", 8'h00, 8'(wq.size()));
        summarize();
    end
endmodule : tb_top
